// ==== logic/mtc_cfg.svh ====
// Register offsets, field positions, reset values and bus response codes of the timer core.
`ifndef MTC_CFG_SVH
`define MTC_CFG_SVH
`define MTC_OFF_STATUS_CTRL 5'h00
`define MTC_OFF_CNT_HIGH 5'h04
`define MTC_OFF_CNT_LOW 5'h08
`define MTC_OFF_MOD_HIGH 5'h0c
`define MTC_OFF_MOD_LOW 5'h10
`define MTC_ADDR_W 5
`define MTC_BIT_OVF 7
`define MTC_BIT_IRQ_EN 6
`define MTC_BIT_HALT 5
`define MTC_BIT_CNT_RESET 4
`define MTC_SEL_LSB 0
`define MTC_SEL_EXT 3'h7
`define MTC_MOD_RESET 16'hffff
`define MTC_CNT_ZERO 16'h0000
`define MTC_RESP_OKAY 2'h0
`define MTC_RESP_SLVERR 2'h2
`endif

// ==== logic/mtc_pkg.sv ====
// Types shared by the timer core: bus channel carriers and status bundle.
package mtc_pkg;
    typedef struct packed {
        logic [4:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } mtc_wreq_s;
    typedef struct packed {
        logic stopped;
        logic halted;
        logic overflow_event;
        logic capture_inhibit;
    } mtc_state_s;
    typedef logic [2:0] mtc_clock_select_t;
endpackage

// ==== logic/mtc_timer_core.sv ====
// Counter core of the six-channel timer unit with an AXI4-Lite register slave.
//
// Contract
// - In low-power stop the timer freezes, keeping registers and counter, then resumes.
// - During debug break the counter halts and input captures are suppressed.
// - With break clear enable low, break-time accesses leave status flags untouched.
// - With break clear enable high, flags cleared during break stay cleared.
// - First clear step before a protected break survives; second step after clears.
// - External clock selected forces the shared pin to input mode.
// - Clock select 000..110 divides bus clock by 1..64; 111 uses external pin.
// - Overflow flag sets when the counter reaches the modulo value.
// - Overflow flag clears only by status read with flag set then zero write.
// - Overflow between the read and the zero write cancels that clear.
// - Overflow interrupt request is flag and enable; reset clears enable.
// - Halt bit stops counting; reset sets it.
// - Halt bit inhibits input captures.
// - Counter-reset bit clears counter and prescaler, self clears, reads zero.
// - Halt and counter-reset written together leave counter halted at zero.
// - High-byte read latches low byte; low-byte read returns it and releases.
// - Repeated high-byte reads keep the latched low byte.
// - Counter registers are read-only, cleared by reset and counter reset.
// - Modulo high write suppresses overflow flag until modulo low is written.
// - Reset loads modulo with all ones.
//
// Behaviour notes for users of this core.
// The overflow flag rises on the tick at which the counter arrives at the modulo value.
// The counter then wraps to zero on the following tick, so one period is modulo plus one.
// A modulo of zero raises the flag only when a higher count wraps naturally to zero; a counter already at zero never arrives at it.
// The modulo high byte is staged; nothing changes until the low byte is written.
// While the high byte is staged the flag is held off, but the pulse toward the
// channels still fires, so channel logic keeps its period during a modulo update.
// Software should reset the counter before changing the modulo; otherwise a new
// modulo below the current count lets the counter run on to the natural wrap.
// The counter low byte latch is released only by a low byte read, also in break.
// A debugger that reads the high byte in break must read the low byte before leaving.
// The flag clear is a two-step sequence: a status read with the flag set arms it,
// and the next status write with the flag bit at zero clears it.
// Any status write disarms, and a new overflow disarms and wins over a clear.
// In a protected break the arm state is frozen so the sequence survives the break.
// The external clock pin is synchronised by two flops, so its high and low times
// must each last at least two bus clocks to be seen as one rising edge.
// Bus writes and reads take a few cycles; the slave never answers combinationally.
// Only the low byte lane carries register data; other lanes are ignored.
// Offsets that map to no register answer with a slave error and read as zero.
// Every output of this module comes straight from a flip-flop.
//
// The placing of the registers and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "mtc_cfg.svh"

module mtc_timer_core #(
    parameter int CNT_W = 16,
    parameter int PRESCALE_W = 6
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [`MTC_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [`MTC_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    input wire logic stop_mode,
    input wire logic debug_break,
    input wire logic break_clear_enable,
    input wire logic external_timer_clock,
    output logic ext_clock_pin_input,
    output logic [CNT_W-1:0] counter_value,
    output logic overflow_pulse,
    output logic counter_halt,
    output logic capture_inhibit,
    output logic overflow_irq
);
    import mtc_pkg::*;

    // Control and status state.
    logic overflow_flag_reg;
    logic overflow_irq_enable_reg;
    logic counter_halt_reg;
    mtc_clock_select_t clock_select_reg;
    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] modulo_reg;
    logic [7:0] modulo_high_stage_reg;
    logic modulo_pending_reg;
    logic [7:0] low_latch_reg;
    logic low_latched_reg;
    logic clear_armed_reg;
    logic [PRESCALE_W-1:0] prescale_reg;
    logic ext_sync1_reg;
    logic ext_sync2_reg;
    logic ext_prev_reg;

    // Bus channel state.
    logic aw_held_reg;
    logic w_held_reg;
    mtc_wreq_s wreq_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;

    // Derived state bundle.
    mtc_state_s st;
    logic tick;
    logic reach;
    logic arrive;
    logic cnt_reset_w;
    logic do_write;
    logic do_read;
    logic wr_hit;
    logic flag_protect;
    logic ovf_set;

    // Byte-offset match used by both the write and read decoders.
    function automatic logic addr_is(input logic [`MTC_ADDR_W-1:0] a,
                                     input logic [`MTC_ADDR_W-1:0] off);
        return a == off;
    endfunction

    function automatic logic is_mapped(input logic [`MTC_ADDR_W-1:0] a);
        return addr_is(a, `MTC_OFF_STATUS_CTRL) || addr_is(a, `MTC_OFF_CNT_HIGH) ||
               addr_is(a, `MTC_OFF_CNT_LOW) || addr_is(a, `MTC_OFF_MOD_HIGH) ||
               a == `MTC_ADDR_W'(`MTC_OFF_MOD_LOW);
    endfunction

    // Write address and data are taken independently, then retired together.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            wreq_reg <= '0;
        end else if (do_write) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
        end else begin
            if (s_axi_awvalid && !aw_held_reg) begin
                aw_held_reg <= 1'b1;
                wreq_reg.addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_held_reg) begin
                w_held_reg <= 1'b1;
                wreq_reg.data <= s_axi_wdata;
                wreq_reg.strb <= s_axi_wstrb;
            end
        end
    end

    assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
    assign wr_hit = do_write && wreq_reg.strb[0];
    assign do_read = s_axi_arvalid && s_axi_arready;

    // Ready flags are registered so the outputs come from flip-flops.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held_reg && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_held_reg && !s_axi_wready && s_axi_wvalid;
            s_axi_arready <= !rvalid_reg && !s_axi_arready && s_axi_arvalid;
        end
    end

    // Write response: unmapped offsets answer with a slave error.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= `MTC_RESP_OKAY;
        end else if (do_write) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= is_mapped(wreq_reg.addr) ? `MTC_RESP_OKAY : `MTC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // Read data path; the counter low byte comes from the latch while it is held.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= `MTC_RESP_OKAY;
        end else if (do_read) begin
            rvalid_reg <= 1'b1;
            rresp_reg <= is_mapped(s_axi_araddr) ? `MTC_RESP_OKAY : `MTC_RESP_SLVERR;
            rdata_reg <= '0;
            if (addr_is(s_axi_araddr, `MTC_OFF_STATUS_CTRL)) begin
                rdata_reg[`MTC_BIT_OVF] <= overflow_flag_reg;
                rdata_reg[`MTC_BIT_IRQ_EN] <= overflow_irq_enable_reg;
                rdata_reg[`MTC_BIT_HALT] <= counter_halt_reg;
                rdata_reg[`MTC_SEL_LSB +: 3] <= clock_select_reg;
            end else if (addr_is(s_axi_araddr, `MTC_OFF_CNT_HIGH)) begin
                rdata_reg[7:0] <= count_reg[15:8];
            end else if (addr_is(s_axi_araddr, `MTC_OFF_CNT_LOW)) begin
                rdata_reg[7:0] <= low_latched_reg ? low_latch_reg : count_reg[7:0];
            end else if (addr_is(s_axi_araddr, `MTC_OFF_MOD_HIGH)) begin
                rdata_reg[7:0] <= modulo_reg[15:8];
            end else if (addr_is(s_axi_araddr, `MTC_OFF_MOD_LOW)) begin
                rdata_reg[7:0] <= modulo_reg[7:0];
            end
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // External clock pin passes two flops before the edge detector reads it.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_sync1_reg <= 1'b0;
            ext_sync2_reg <= 1'b0;
            ext_prev_reg <= 1'b0;
        end else begin
            ext_sync1_reg <= external_timer_clock;
            ext_sync2_reg <= ext_sync1_reg;
            ext_prev_reg <= ext_sync2_reg;
        end
    end

    // Frozen in stop mode, debug break or halt; counting resumes when all clear.
    assign st.stopped = stop_mode;
    assign st.halted = counter_halt_reg || stop_mode || debug_break;
    assign st.capture_inhibit = counter_halt_reg || debug_break;
    assign cnt_reset_w = wr_hit && addr_is(wreq_reg.addr, `MTC_OFF_STATUS_CTRL) &&
                         wreq_reg.data[`MTC_BIT_CNT_RESET];

    // Tick select: bus clock divided by 2^code, or rising edge of the pin.
    always_comb begin
        if (clock_select_reg == `MTC_SEL_EXT) begin
            tick = ext_sync2_reg && !ext_prev_reg;
        end else if (clock_select_reg == 3'h0) begin
            tick = 1'b1;
        end else begin
            tick = &prescale_reg[clock_select_reg - 3'h1 -: 1] &&
                   (prescale_reg & PRESCALE_W'((1 << clock_select_reg) - 1)) ==
                   PRESCALE_W'((1 << clock_select_reg) - 1);
        end
    end

    // Wrap happens on the tick after the match; the flag rises as the match is reached.
    assign reach = tick && !st.halted && count_reg == modulo_reg;
    assign arrive = tick && !st.halted && !reach && count_reg + CNT_W'(1) == modulo_reg;
    assign st.overflow_event = arrive;
    assign ovf_set = arrive && !modulo_pending_reg;

    // Prescaler runs synchronously and is cleared by counter reset.
    always_ff @(posedge aclk) begin
        if (!aresetn || cnt_reset_w) begin
            prescale_reg <= '0;
        end else if (!st.halted) begin
            prescale_reg <= prescale_reg + PRESCALE_W'(1);
        end
    end

    // Counter: increments per tick and wraps to zero after modulo match.
    always_ff @(posedge aclk) begin
        if (!aresetn || cnt_reset_w) begin
            count_reg <= `MTC_CNT_ZERO;
        end else if (tick && !st.halted) begin
            count_reg <= reach ? `MTC_CNT_ZERO : count_reg + CNT_W'(1);
        end
    end

    // Control bits; a halt written with counter reset leaves the count at zero.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            overflow_irq_enable_reg <= 1'b0;
            counter_halt_reg <= 1'b1;
            clock_select_reg <= '0;
        end else if (wr_hit && addr_is(wreq_reg.addr, `MTC_OFF_STATUS_CTRL)) begin
            overflow_irq_enable_reg <= wreq_reg.data[`MTC_BIT_IRQ_EN];
            counter_halt_reg <= wreq_reg.data[`MTC_BIT_HALT];
            clock_select_reg <= wreq_reg.data[`MTC_SEL_LSB +: 3];
        end
    end

    // Modulo pair: high byte is staged and takes effect with the low byte.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            modulo_reg <= `MTC_MOD_RESET;
            modulo_high_stage_reg <= 8'(`MTC_MOD_RESET >> 8);
            modulo_pending_reg <= 1'b0;
        end else if (wr_hit && addr_is(wreq_reg.addr, `MTC_OFF_MOD_HIGH)) begin
            modulo_high_stage_reg <= wreq_reg.data[7:0];
            modulo_pending_reg <= 1'b1;
        end else if (wr_hit && wreq_reg.addr == `MTC_ADDR_W'(`MTC_OFF_MOD_LOW)) begin
            modulo_reg <= {modulo_high_stage_reg, wreq_reg.data[7:0]};
            modulo_pending_reg <= 1'b0;
        end
    end

    // Low-byte latch: the first high read captures, later high reads do not.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            low_latch_reg <= '0;
            low_latched_reg <= 1'b0;
        end else if (do_read && addr_is(s_axi_araddr, `MTC_OFF_CNT_HIGH)) begin
            if (!low_latched_reg) begin
                low_latch_reg <= count_reg[7:0];
                low_latched_reg <= 1'b1;
            end
        end else if (do_read && addr_is(s_axi_araddr, `MTC_OFF_CNT_LOW)) begin
            low_latched_reg <= 1'b0;
        end
    end

    // Break protection: with clear enable low, accesses in break touch no flag state.
    assign flag_protect = debug_break && !break_clear_enable;

    // Two-step clear; the arming read survives a protected break.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clear_armed_reg <= 1'b0;
        end else if (ovf_set) begin
            clear_armed_reg <= 1'b0;
        end else if (flag_protect) begin
            clear_armed_reg <= clear_armed_reg;
        end else if (do_read && addr_is(s_axi_araddr, `MTC_OFF_STATUS_CTRL)) begin
            clear_armed_reg <= overflow_flag_reg;
        end else if (wr_hit && addr_is(wreq_reg.addr, `MTC_OFF_STATUS_CTRL)) begin
            clear_armed_reg <= 1'b0;
        end
    end

    // Overflow flag: set wins over clear; a zero write clears only when armed.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            overflow_flag_reg <= 1'b0;
        end else if (ovf_set) begin
            overflow_flag_reg <= 1'b1;
        end else if (!flag_protect && clear_armed_reg && wr_hit &&
                     addr_is(wreq_reg.addr, `MTC_OFF_STATUS_CTRL) &&
                     !wreq_reg.data[`MTC_BIT_OVF]) begin
            overflow_flag_reg <= 1'b0;
        end
    end

    // Registered outputs toward the pins, channels and interrupt controller.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_clock_pin_input <= 1'b0;
            counter_value <= '0;
            overflow_pulse <= 1'b0;
            counter_halt <= 1'b1;
            capture_inhibit <= 1'b1;
            overflow_irq <= 1'b0;
        end else begin
            ext_clock_pin_input <= clock_select_reg == `MTC_SEL_EXT;
            counter_value <= count_reg;
            overflow_pulse <= st.overflow_event;
            counter_halt <= st.halted;
            capture_inhibit <= st.capture_inhibit;
            overflow_irq <= overflow_flag_reg && overflow_irq_enable_reg;
        end
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
endmodule

// ==== verification/mtc_core_monitor.sv ====
// Port-level assertions for the timer core, bound to every core instance.
`timescale 1ns/1ps
module mtc_core_monitor #(
    parameter int CNT_W = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic stop_mode,
    input wire logic debug_break,
    input wire logic [CNT_W-1:0] counter_value,
    input wire logic counter_halt,
    input wire logic capture_inhibit,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp
);
    // One clock domain, so the checks share a clock and stay quiet in reset.
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    stop_freeze_a: assert property (stop_mode [*3] |-> $stable(counter_value))
        else $error("counter moved in low-power stop");
    break_freeze_a: assert property (debug_break [*3] |-> $stable(counter_value))
        else $error("counter moved during break");
    break_inhibit_a: assert property (debug_break |=> capture_inhibit)
        else $error("captures not inhibited in break");
    // A counter reset may still zero a halted counter, so zero is allowed.
    halt_hold_a: assert property (counter_halt [*3] |-> $stable(counter_value) || counter_value == '0)
        else $error("counter moved while halted");
    inhibit_halt_a: assert property (capture_inhibit |-> counter_halt)
        else $error("capture inhibit without halt");
    count_step_a: assert property (!$stable(counter_value) |->
        counter_value == CNT_W'($past(counter_value) + 1) || counter_value == '0)
        else $error("counter jumped");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped early");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped early");
    unmapped_zero_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
        else $error("error read returned data");
endmodule
bind mtc_timer_core mtc_core_monitor #(.CNT_W(CNT_W)) i_mtc_core_monitor (
    .aclk(aclk), .aresetn(aresetn), .stop_mode(stop_mode), .debug_break(debug_break),
    .counter_value(counter_value), .counter_halt(counter_halt),
    .capture_inhibit(capture_inhibit), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp)
);

// ==== verification/testbench.sv ====
// Self-checking bench for the timer core: registers, counting, flags and freezes.
`timescale 1ns/1ps
module testbench;
    localparam logic [4:0] ST = 5'h00, CH = 5'h04, CL = 5'h08, MH = 5'h0c, ML = 5'h10;
    localparam logic [1:0] OK = 2'h0, ERR = 2'h2;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic stop_mode = 1'b0, debug_break = 1'b0, break_clear_enable = 1'b0, ext_clk = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic ext_clock_pin_input, overflow_pulse, counter_halt, capture_inhibit, overflow_irq;
    logic [15:0] counter_value, v1;
    logic [7:0] lf = 8'h14;
    logic [33:0] rq[$];
    logic [1:0] bq[$];
    int bad_count = 0, compares = 0, cycles = 0, n, pulses = 0;
    // Free-running 50 MHz bus clock.
    always #10 aclk = ~aclk;
    mtc_timer_core i_mtc_timer_core (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(4'hf), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .stop_mode(stop_mode), .debug_break(debug_break),
        .break_clear_enable(break_clear_enable), .external_timer_clock(ext_clk),
        .ext_clock_pin_input(ext_clock_pin_input), .counter_value(counter_value),
        .overflow_pulse(overflow_pulse), .counter_halt(counter_halt),
        .capture_inhibit(capture_inhibit), .overflow_irq(overflow_irq)
    );
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic cmp(input logic [33:0] e, input logic [33:0] g);
        compares++;
        if (e !== g) begin
            bad_count++;
            $display("CHECK FAILED at %0t: expected %h got %h", $time, e, g);
        end
    endtask
    task automatic chk(input logic [15:0] e, input logic [15:0] g);
        cmp({18'h0, e}, {18'h0, g});
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Answers are compared here, oldest expectation first; a hang ends the run.
    always @(posedge aclk) begin
        if (s_axi_rvalid && s_axi_rready)
            cmp(rq.pop_front(), {s_axi_rresp, s_axi_rdata});
        if (s_axi_bvalid && s_axi_bready)
            cmp({32'h0, bq.pop_front()}, {32'h0, s_axi_bresp});
        if (overflow_pulse)
            pulses++;
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            summarize();
        end
    end
    // One bus transfer; ready for the answer is raised early and held until taken.
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
                       input logic [1:0] r);
        logic done;
        done = 1'b0;
        if (w)
            bq.push_back(r);
        else
            rq.push_back({r, 24'h0, d});
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= w;
        s_axi_wvalid <= w;
        s_axi_arvalid <= !w;
        while (!done) begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
            done = (s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready);
            s_axi_bready <= w && !done;
            s_axi_rready <= !w && !done;
        end
    endtask
    // Pulses on the external clock pin, with randomised high time.
    task automatic tick(input int k);
        repeat (k) begin
            lf = lfsr(lf);
            ext_clk <= 1'b1;
            repeat (3 + lf[0]) @(posedge aclk);
            ext_clk <= 1'b0;
            repeat (3) @(posedge aclk);
        end
        repeat (4) @(posedge aclk);
    endtask
    // Counts advance over 128 bus cycles, a multiple of every divide ratio.
    task automatic meas(input logic [7:0] ctl, input logic st, input logic bk,
                        input logic [15:0] e);
        bus(1'b1, ST, ctl, OK);
        stop_mode <= st;
        debug_break <= bk;
        repeat (4) @(posedge aclk);
        v1 = counter_value;
        repeat (128) @(posedge aclk);
        chk(e, counter_value - v1);
        chk({15'h0, bk | ctl[5]}, {15'h0, capture_inhibit});
        stop_mode <= 1'b0;
        debug_break <= 1'b0;
    endtask
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        bus(1'b0, ST, 8'h20, OK);
        bus(1'b0, MH, 8'hff, OK);
        bus(1'b0, ML, 8'hff, OK);
        bus(1'b0, 5'h14, 8'h00, ERR);
        bus(1'b1, 5'h14, 8'h00, ERR);
        $display("test reset_values done");
        for (int c = 0; c < 7; c++)
            meas(8'h10 | 8'(c), 1'b0, 1'b0, 16'h80 >> c);
        meas(8'h10, 1'b1, 1'b0, 16'h0);
        meas(8'h10, 1'b0, 1'b1, 16'h0);
        meas(8'h30, 1'b0, 1'b0, 16'h0);
        $display("test prescaler_freeze done");
        bus(1'b1, ST, 8'h57, OK);
        @(posedge aclk);
        chk(16'h1, {15'h0, ext_clock_pin_input});
        bus(1'b1, MH, 8'h00, OK);
        bus(1'b1, ML, 8'h05, OK);
        lf = lfsr(lf);
        n = lf[1:0] + 1;
        tick(n);
        bus(1'b0, CH, 8'h00, OK);
        tick(1);
        bus(1'b0, CH, 8'h00, OK);
        bus(1'b0, CL, 8'(n), OK);
        bus(1'b0, CL, 8'(n + 1), OK);
        tick(4 - n);
        bus(1'b1, ST, 8'h47, OK);
        bus(1'b0, ST, 8'hc7, OK);
        chk(16'h1, {15'h0, overflow_irq});
        tick(1);
        bus(1'b0, CL, 8'h00, OK);
        bus(1'b1, ST, 8'h47, OK);
        bus(1'b0, ST, 8'h47, OK);
        chk(16'h0, {15'h0, overflow_irq});
        bus(1'b1, ST, 8'hc7, OK);
        bus(1'b0, ST, 8'h47, OK);
        tick(5);
        bus(1'b0, ST, 8'hc7, OK);
        tick(6);
        bus(1'b1, ST, 8'h47, OK);
        bus(1'b0, ST, 8'hc7, OK);
        $display("test overflow_flag done");
        debug_break <= 1'b1;
        bus(1'b1, ST, 8'h47, OK);
        bus(1'b0, ST, 8'hc7, OK);
        bus(1'b0, CH, 8'h00, OK);
        bus(1'b0, CL, 8'h05, OK);
        debug_break <= 1'b0;
        bus(1'b1, ST, 8'h47, OK);
        bus(1'b0, ST, 8'h47, OK);
        tick(6);
        debug_break <= 1'b1;
        break_clear_enable <= 1'b1;
        bus(1'b0, ST, 8'hc7, OK);
        bus(1'b1, ST, 8'h47, OK);
        debug_break <= 1'b0;
        break_clear_enable <= 1'b0;
        bus(1'b0, ST, 8'h47, OK);
        $display("test break done");
        bus(1'b1, ST, 8'h57, OK);
        bus(1'b1, MH, 8'h00, OK);
        tick(5);
        bus(1'b0, ST, 8'h47, OK);
        bus(1'b1, ML, 8'h03, OK);
        bus(1'b1, ST, 8'h57, OK);
        tick(3);
        bus(1'b0, ST, 8'hc7, OK);
        bus(1'b1, CH, 8'h12, OK);
        bus(1'b0, CH, 8'h00, OK);
        bus(1'b0, CL, 8'h03, OK);
        bus(1'b1, ST, 8'h37, OK);
        tick(2);
        bus(1'b0, CH, 8'h00, OK);
        bus(1'b0, CL, 8'h00, OK);
        bus(1'b0, ST, 8'h27, OK);
        chk(16'h1, {15'h0, counter_halt});
        chk(16'h6, 16'(pulses));
        $display("test modulo_halt done");
        summarize();
    end
endmodule
